// *** src/fcs_pkg.sv ***
package fcs_pkg;
  // register addresses on the serial link
  localparam logic [31:0] A_MODE     = 32'h0000_0000;
  localparam logic [31:0] A_DUMMY    = 32'h0000_0300;
  localparam logic [31:0] A_PREAMBLE = 32'h0000_0500;
  localparam logic [31:0] A_ECC_STAT = 32'h0000_0800;
  localparam logic [31:0] A_FA0      = 32'h0000_0c00;
  localparam logic [31:0] A_FA1      = 32'h0000_0d00;
  localparam logic [31:0] A_FA2      = 32'h0000_0e00;
  localparam logic [31:0] A_FA3      = 32'h0000_0f00;
  localparam logic [31:0] A_OTP_CFG  = 32'h4000_0000;
  localparam logic [31:0] A_PAR_FAIL = 32'h8000_0000;
  localparam logic [31:0] DIE_MASK   = 32'h0c00_0000;
  localparam int          DIE_LSB    = 26;
  localparam int          NUM_DIES   = 4;
  // link opcodes
  localparam logic [7:0] OP_RD_CFG2 = 8'h71;
  localparam logic [7:0] OP_WR_CFG2 = 8'h72;
  localparam logic [7:0] OP_RD_SCUR = 8'h2b;
  localparam logic [7:0] OP_WR_SCUR = 8'h2f;
  // field positions
  localparam int OTP_PAR_DIS_BIT = 3;
  localparam int PAR_FAIL_BIT    = 4;
  localparam int SC_LOCK_BIT     = 1;
  localparam logic [1:0] MODE_INHIBIT = 2'h3;
  localparam logic [7:0] OTP_RSVD_ONES = 8'hf4;
  localparam logic [7:0] CLEAR_VALUE   = 8'h00;
  // dummy cycles: count = max - step * code
  localparam logic [4:0] DUMMY_MAX = 5'h14;
  // preamble words
  localparam logic [15:0] PRE_MAIN = 16'h349a;
  localparam logic [15:0] PRE_L3   = 16'h3514;
  localparam logic [15:0] PRE_ALT  = 16'h5555;
  // ecc chunk address holds a[25:4]
  localparam int         CHUNK_W = 22;
  localparam logic [3:0] CNT_MAX = 4'hf;
  // bit counters of the link frame
  localparam logic [5:0] BYTE_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h1f;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DIN  = 6'h08,
    ST_DOUT = 6'h10,
    ST_SKIP = 6'h20
  } fcs_state_e;
endpackage : fcs_pkg

// *** src/fcs_ecc_if.sv ***
`timescale 1ns/100ps
interface fcs_ecc_if;
  import fcs_pkg::*;
  logic               ev;
  logic               clr;
  logic [CHUNK_W-1:0] ev_addr;
  logic [2:0]         ev_kind;
  logic               valid;
  logic [2:0]         status;
  logic [3:0]         count;
  logic [CHUNK_W-1:0] addr;
  modport tracker (input ev, clr, ev_addr, ev_kind,
                   output valid, status, count, addr);
  modport bank (output ev, clr, ev_addr, ev_kind,
                input valid, status, count, addr);
endinterface : fcs_ecc_if

// *** src/fcs_ecc_die.sv ***
`timescale 1ns/100ps
module fcs_ecc_die (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  fcs_ecc_if.tracker eif
);
  import fcs_pkg::*;

  logic               valid_reg, valid_next;
  logic [2:0]         stat_reg,  stat_next;
  logic [3:0]         cnt_reg,   cnt_next;
  logic [CHUNK_W-1:0] addr_reg,  addr_next;

  // clear first, then a same-cycle failure is still recorded
  always_comb begin
    valid_next = valid_reg;
    stat_next  = stat_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    if (eif.clr) begin
      valid_next = 1'b0;
      stat_next  = 3'h0;
      cnt_next   = 4'h0;
    end
    if (eif.ev) begin
      if (!valid_next) addr_next = eif.ev_addr;
      valid_next = 1'b1;
      stat_next  = stat_next | eif.ev_kind;
      if (cnt_next != CNT_MAX) cnt_next = cnt_next + 4'h1;
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      valid_reg <= 1'b0;
      stat_reg  <= 3'h0;
      cnt_reg   <= 4'h0;
      addr_reg  <= '0;
    end else if (clk_en) begin
      valid_reg <= valid_next;
      stat_reg  <= stat_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
    end
  end

  assign eif.valid  = valid_reg;
  assign eif.status = stat_reg;
  assign eif.count  = cnt_reg;
  assign eif.addr   = addr_reg;
endmodule : fcs_ecc_die

// *** src/fcs_top.sv ***
// Notes on behaviour
// - chunk address bits spread over four bytes
// - only first failing chunk address is latched
// - address meaningful only while valid reads one
// - failure counter counts every failure, saturates fifteen
// - address bits 27:26 pick the die
// - writing zero to 0x800 clears ecc status
// - writing zero to 0x80000000 clears fail flag
// - otp bit3 low enables parity checking
// - otp boot bits pick power-on interface
// - mode loads from boot bits one cycle after reset
// - dummy code maps to twenty down six
// - preamble select picks the line patterns
// - erase fail flag follows last erase
// - program fail flag follows last program
// - erase suspended flag tracks suspend, resume
// - program suspended flag tracks suspend, resume
// - bit0 reports factory lock of otp
// - lockdown set once, then otp write allow drops; otp config writes still raise a program request
// - no array access in secured otp mode
// - bit7 selects block protection mode
// - read takes opcode, four address bytes, data
// - reads refused while writing, except fail flag and security
`timescale 1ns/100ps
module fcs_top (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic               cs_n,
  input  wire logic               sclk,
  input  wire logic               si,
  output logic                    so_out,
  output logic                    so_oe_n,
  input  wire logic               write_in_progress,
  input  wire logic [7:0]         nv_cfg_byte,
  input  wire logic               nv_protect_mode_sel,
  input  wire logic               nv_otp_lockdown,
  input  wire logic               nv_factory_lock,
  input  wire logic               otp_mode_active,
  input  wire logic               ecc_fail_pulse,
  input  wire logic [1:0]         ecc_fail_die,
  input  wire logic [fcs_pkg::CHUNK_W-1:0] ecc_fail_chunk,
  input  wire logic [2:0]         ecc_fail_kind,
  input  wire logic               cmd_check_fail,
  input  wire logic               parity_check_fail,
  input  wire logic               erase_done,
  input  wire logic               erase_failed,
  input  wire logic               program_done,
  input  wire logic               program_failed,
  input  wire logic               erase_suspend,
  input  wire logic               erase_resume,
  input  wire logic               program_suspend,
  input  wire logic               program_resume,
  output logic                    double_rate_octal_on,
  output logic                    single_rate_octal_on,
  output logic [2:0]              dummy_cycle_sel,
  output logic [4:0]              dummy_cycle_count,
  output logic                    preamble_pattern_sel,
  output logic [15:0]             preamble_main,
  output logic [15:0]             preamble_io_line3,
  output logic                    parity_check_en,
  output logic                    cmd_parity_fail_flag,
  output logic                    protect_mode_sel,
  output logic                    otp_lockdown_bit,
  output logic                    otp_area_write_allow,
  output logic                    array_access_allow,
  output logic                    erase_fail_flag,
  output logic                    program_fail_flag,
  output logic                    erase_suspended_flag,
  output logic                    program_suspended_flag,
  output logic                    otp_prog_req,
  output logic                    otp_prog_scur,
  output logic [7:0]              otp_prog_byte
);
  import fcs_pkg::*;

  // link pins are asynchronous to mclk
  logic cs_s1, cs_s2, sck_s1, sck_s2, sck_s3, si_s1, si_s2;
  logic sck_rise, sck_fall;

  // link frame state
  fcs_state_e st_reg, st_next;
  logic [5:0]  bits_reg,  bits_next;
  logic [31:0] shift_reg, shift_next;
  logic [7:0]  cmd_reg,   cmd_next;
  logic [31:0] addr_reg,  addr_next;
  logic [7:0]  tx_reg,    tx_next;
  logic        so_reg,    so_next;
  logic        oen_reg,   oen_next;
  logic        wr_stb, lock_stb;
  logic [31:0] rd_addr, wr_low, rd_low;
  logic [7:0]  wr_data, rd_byte, scur_byte;
  logic [1:0]  rd_die;

  // configuration and status
  logic [1:0]  mode_reg,  mode_next;
  logic        load_reg,  load_next;
  logic [2:0]  dc_reg,    dc_next;
  logic [4:0]  dcnt_reg,  dcnt_next;
  logic        ppt_reg,   ppt_next;
  logic [15:0] prem_reg,  prem_next;
  logic [15:0] prel3_reg, prel3_next;
  logic        pfl_reg,   pfl_next;
  logic        ef_reg,    ef_next;
  logic        pf_reg,    pf_next;
  logic        es_reg,    es_next;
  logic        ps_reg,    ps_next;
  logic        pce_reg,   pce_next;
  logic        pms_reg,   pms_next;
  logic        lck_reg,   lck_next;
  logic        arr_reg,   arr_next;
  logic        prq_reg,   prq_next;
  logic        pscur_reg, pscur_next;
  logic [7:0]  pbyte_reg, pbyte_next;

  // per-die ecc status for the read mux
  logic               die_valid [NUM_DIES];
  logic [2:0]         die_stat  [NUM_DIES];
  logic [3:0]         die_cnt   [NUM_DIES];
  logic [CHUNK_W-1:0] die_addr  [NUM_DIES];

  fcs_ecc_if eif [NUM_DIES] ();

  // one tracker per stacked die
  for (genvar g = 0; g < NUM_DIES; g++) begin : g_die
    assign eif[g].ev      = ecc_fail_pulse &&
                            (ecc_fail_die == 2'(g));
    assign eif[g].ev_addr = ecc_fail_chunk;
    assign eif[g].ev_kind = ecc_fail_kind;
    assign eif[g].clr     = wr_stb && (wr_low == A_ECC_STAT) &&
                            (wr_data == CLEAR_VALUE) &&
                            (addr_reg[DIE_LSB +: 2] == 2'(g));
    assign die_valid[g] = eif[g].valid;
    assign die_stat[g]  = eif[g].status;
    assign die_cnt[g]   = eif[g].count;
    assign die_addr[g]  = eif[g].addr;
    fcs_ecc_die u_die (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .clk_en (clk_en),
      .eif    (eif[g])
    );
  end

  // two-flop synchronisers; third sclk flop for edges
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
    end else if (clk_en) begin
      cs_s1  <= cs_n;
      cs_s2  <= cs_s1;
      sck_s1 <= sclk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1  <= si;
      si_s2  <= si_s1;
    end
  end

  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign rd_addr  = {shift_reg[30:0], si_s2};
  assign wr_data  = rd_addr[7:0];
  assign wr_low   = addr_reg & ~DIE_MASK;
  assign rd_low   = rd_addr & ~DIE_MASK;
  assign rd_die   = rd_addr[DIE_LSB +: 2];
  assign scur_byte = {pms_reg, ef_reg, pf_reg, 1'b0, es_reg, ps_reg,
                      lck_reg, nv_factory_lock};

  // read data for the address just completed
  always_comb begin
    rd_byte = 8'h00;
    case (rd_low)
      A_MODE:     rd_byte = {6'h00, mode_reg};
      A_DUMMY:    rd_byte = {5'h00, dc_reg};
      A_PREAMBLE: rd_byte = {7'h00, ppt_reg};
      A_ECC_STAT: rd_byte = {die_valid[rd_die], die_stat[rd_die],
                             die_cnt[rd_die]};
      A_FA0:      rd_byte = {die_addr[rd_die][3:0], 4'h0};
      A_FA1:      rd_byte = die_addr[rd_die][11:4];
      A_FA2:      rd_byte = die_addr[rd_die][19:12];
      A_FA3:      rd_byte = {6'h00, die_addr[rd_die][21:20]};
      A_OTP_CFG:  rd_byte = nv_cfg_byte | OTP_RSVD_ONES;
      A_PAR_FAIL: rd_byte = {3'h0, pfl_reg, 4'h0};
      default:    rd_byte = 8'h00;
    endcase
  end

  // link frame: opcode, address, data byte or read stream
  always_comb begin
    st_next    = st_reg;
    bits_next  = bits_reg;
    shift_next = shift_reg;
    cmd_next   = cmd_reg;
    addr_next  = addr_reg;
    tx_next    = tx_reg;
    so_next    = so_reg;
    oen_next   = oen_reg;
    wr_stb     = 1'b0;
    lock_stb   = 1'b0;
    if (cs_s2) begin
      st_next  = ST_IDLE;
      oen_next = 1'b1;
    end else begin
      if (sck_rise) begin
        shift_next = rd_addr;
        bits_next  = bits_reg + 6'h01;
      end
      case (st_reg)
        ST_IDLE: begin
          st_next   = ST_CMD;
          bits_next = 6'h00;
        end
        ST_CMD: begin
          if (sck_rise && bits_reg == BYTE_LAST) begin
            bits_next = 6'h00;
            cmd_next  = wr_data;
            if (wr_data == OP_RD_CFG2 || wr_data == OP_WR_CFG2) begin
              st_next = ST_ADDR;
            end else if (wr_data == OP_RD_SCUR) begin
              st_next = ST_DOUT;
              tx_next = scur_byte;
            end else begin
              st_next  = ST_SKIP;
              // lockdown can be set once only
              lock_stb = (wr_data == OP_WR_SCUR) &&
                         !write_in_progress && !lck_reg;
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise && bits_reg == ADDR_LAST) begin
            bits_next = 6'h00;
            addr_next = rd_addr;
            if (write_in_progress &&
                !(cmd_reg == OP_RD_CFG2 && rd_addr == A_PAR_FAIL)) begin
              st_next = ST_SKIP;
            end else if (cmd_reg == OP_RD_CFG2) begin
              st_next = ST_DOUT;
              tx_next = rd_byte;
            end else begin
              st_next = ST_DIN;
            end
          end
        end
        ST_DIN: begin
          if (sck_rise && bits_reg == BYTE_LAST) begin
            wr_stb  = 1'b1;
            st_next = ST_SKIP;
          end
        end
        ST_DOUT: begin
          // shift out msb first on falling edges; byte repeats
          if (sck_fall) begin
            so_next  = tx_reg[7];
            tx_next  = {tx_reg[6:0], tx_reg[7]};
            oen_next = 1'b0;
          end
        end
        ST_SKIP: st_next = ST_SKIP;
        default: st_next = ST_IDLE;
      endcase
    end
  end

  // link frame registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg    <= ST_IDLE;
      bits_reg  <= 6'h00;
      shift_reg <= 32'h0000_0000;
      cmd_reg   <= 8'h00;
      addr_reg  <= 32'h0000_0000;
      tx_reg    <= 8'h00;
      so_reg    <= 1'b0;
      oen_reg   <= 1'b1;
    end else if (clk_en) begin
      st_reg    <= st_next;
      bits_reg  <= bits_next;
      shift_reg <= shift_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      tx_reg    <= tx_next;
      so_reg    <= so_next;
      oen_reg   <= oen_next;
    end
  end

  // config writes, status events, derived outputs
  always_comb begin
    mode_next  = mode_reg;
    load_next  = 1'b0;
    dc_next    = dc_reg;
    ppt_next   = ppt_reg;
    pfl_next   = pfl_reg;
    ef_next    = ef_reg;
    pf_next    = pf_reg;
    es_next    = es_reg;
    ps_next    = ps_reg;
    prq_next   = 1'b0;
    pscur_next = pscur_reg;
    pbyte_next = pbyte_reg;
    // boot selection is inverted into the volatile mode
    if (load_reg) mode_next = ~nv_cfg_byte[1:0];
    if (wr_stb) begin
      case (addr_reg)
        A_MODE:
          if (wr_data[1:0] != MODE_INHIBIT) mode_next = wr_data[1:0];
        A_DUMMY:    dc_next  = wr_data[2:0];
        A_PREAMBLE: ppt_next = wr_data[0];
        A_OTP_CFG: begin
          // otp cells only move from one to zero
          prq_next   = 1'b1;
          pscur_next = 1'b0;
          pbyte_next = nv_cfg_byte & wr_data;
        end
        A_PAR_FAIL:
          if (wr_data == CLEAR_VALUE) pfl_next = 1'b0;
        default: prq_next = 1'b0;
      endcase
    end
    if (lock_stb) begin
      prq_next   = 1'b1;
      pscur_next = 1'b1;
      pbyte_next = scur_byte | (8'h01 << SC_LOCK_BIT);
    end
    // checks report after a clear so a new failure wins
    if (cmd_check_fail || (parity_check_fail && pce_reg))
      pfl_next = 1'b1;
    if (erase_done) ef_next = erase_failed;
    if (program_done) pf_next = program_failed;
    if (erase_resume) es_next = 1'b0;
    if (erase_suspend) es_next = 1'b1;
    if (program_resume) ps_next = 1'b0;
    if (program_suspend) ps_next = 1'b1;
    dcnt_next  = DUMMY_MAX - {1'b0, dc_next, 1'b0};
    prem_next  = ppt_next ? PRE_ALT : PRE_MAIN;
    prel3_next = ppt_next ? PRE_ALT : PRE_L3;
    pce_next   = !nv_cfg_byte[OTP_PAR_DIS_BIT];
    pms_next   = nv_protect_mode_sel;
    lck_next   = nv_otp_lockdown;
    arr_next   = !otp_mode_active;
  end

  // configuration and status registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_reg  <= 2'h0;
      load_reg  <= 1'b1;
      dc_reg    <= 3'h0;
      dcnt_reg  <= DUMMY_MAX;
      ppt_reg   <= 1'b0;
      prem_reg  <= PRE_MAIN;
      prel3_reg <= PRE_L3;
      pfl_reg   <= 1'b0;
      ef_reg    <= 1'b0;
      pf_reg    <= 1'b0;
      es_reg    <= 1'b0;
      ps_reg    <= 1'b0;
      pce_reg   <= 1'b0;
      pms_reg   <= 1'b0;
      lck_reg   <= 1'b0;
      arr_reg   <= 1'b0;
      prq_reg   <= 1'b0;
      pscur_reg <= 1'b0;
      pbyte_reg <= 8'h00;
    end else if (clk_en) begin
      mode_reg  <= mode_next;
      load_reg  <= load_next;
      dc_reg    <= dc_next;
      dcnt_reg  <= dcnt_next;
      ppt_reg   <= ppt_next;
      prem_reg  <= prem_next;
      prel3_reg <= prel3_next;
      pfl_reg   <= pfl_next;
      ef_reg    <= ef_next;
      pf_reg    <= pf_next;
      es_reg    <= es_next;
      ps_reg    <= ps_next;
      pce_reg   <= pce_next;
      pms_reg   <= pms_next;
      lck_reg   <= lck_next;
      arr_reg   <= arr_next;
      prq_reg   <= prq_next;
      pscur_reg <= pscur_next;
      pbyte_reg <= pbyte_next;
    end
  end

  assign so_out                 = so_reg;
  assign so_oe_n                = oen_reg;
  assign double_rate_octal_on   = mode_reg[1];
  assign single_rate_octal_on   = mode_reg[0];
  assign dummy_cycle_sel        = dc_reg;
  assign dummy_cycle_count      = dcnt_reg;
  assign preamble_pattern_sel   = ppt_reg;
  assign preamble_main          = prem_reg;
  assign preamble_io_line3      = prel3_reg;
  assign parity_check_en        = pce_reg;
  assign cmd_parity_fail_flag   = pfl_reg;
  assign protect_mode_sel       = pms_reg;
  assign otp_lockdown_bit       = lck_reg;
  assign otp_area_write_allow   = !lck_reg;
  assign array_access_allow     = arr_reg;
  assign erase_fail_flag        = ef_reg;
  assign program_fail_flag      = pf_reg;
  assign erase_suspended_flag   = es_reg;
  assign program_suspended_flag = ps_reg;
  assign otp_prog_req           = prq_reg;
  assign otp_prog_scur          = pscur_reg;
  assign otp_prog_byte          = pbyte_reg;
endmodule : fcs_top

// *** test/fcs_assertions.sv ***
`timescale 1ns/100ps
module fcs_assertions (
  input logic        mclk,
  input logic        rst_b,
  input logic        clk_en,
  input logic [7:0]  nv_cfg_byte,
  input logic        otp_mode_active,
  input logic        cmd_check_fail,
  input logic        erase_done,
  input logic        erase_failed,
  input logic        program_done,
  input logic        program_failed,
  input logic        erase_suspend,
  input logic        erase_resume,
  input logic [2:0]  dummy_cycle_sel,
  input logic [4:0]  dummy_cycle_count,
  input logic        preamble_pattern_sel,
  input logic [15:0] preamble_main,
  input logic [15:0] preamble_io_line3,
  input logic        parity_check_en,
  input logic        cmd_parity_fail_flag,
  input logic        array_access_allow,
  input logic        erase_fail_flag,
  input logic        program_fail_flag,
  input logic        erase_suspended_flag
);
  import fcs_pkg::*;
  logic par_dis;
  // plain tap so $past sees a signal, not a select
  assign par_dis = nv_cfg_byte[OTP_PAR_DIS_BIT];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_dummy_map: assert property (
    dummy_cycle_count == DUMMY_MAX - {1'b0, dummy_cycle_sel, 1'b0})
    else $error("dummy count");
  a_preamble_map: assert property (
    preamble_main == (preamble_pattern_sel ? PRE_ALT : PRE_MAIN) &&
    preamble_io_line3 == (preamble_pattern_sel ? PRE_ALT : PRE_L3))
    else $error("preamble words");
  a_parity_follow: assert property (
    $past(rst_b) && $past(clk_en) |-> parity_check_en == !$past(par_dis))
    else $error("parity enable");
  a_flag_sticky: assert property (
    clk_en && cmd_check_fail |=> cmd_parity_fail_flag [*2])
    else $error("fail flag not set");
  a_erase_result: assert property (
    clk_en && erase_done |=> erase_fail_flag == $past(erase_failed))
    else $error("erase fail flag");
  a_program_result: assert property (
    clk_en && program_done |=> program_fail_flag == $past(program_failed))
    else $error("program fail flag");
  a_erase_suspend: assert property (
    clk_en && (erase_suspend || erase_resume) |=>
    erase_suspended_flag == $past(erase_suspend))
    else $error("erase suspend flag");
  a_array_block: assert property (
    clk_en |=> array_access_allow == !$past(otp_mode_active))
    else $error("array access");
endmodule : fcs_assertions

bind fcs_top fcs_assertions u_fcs_chk (.*);

// *** test/fcs_host_model.sv ***
`timescale 1ns/100ps
// link host; sclk rests low between frames
module fcs_host_model (
  input wire logic mclk,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic     cs_n,
  output logic     sclk,
  output logic     si
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end
  // nw bits out msb first, then nr bits in; 8 mclk per link clock
  task automatic frame(input logic [47:0] w, input int nw, input int nr,
                       output logic [7:0] rd, output logic drv);
    rd  = 8'h00;
    drv = 1'b0;
    @(posedge mclk) cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nw + nr; i++) begin
      si   <= (i < nw) ? w[47-i] : ~si;
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      if (i >= nw) begin
        // a released line reads as the inverse of its last value
        rd  = {rd[6:0], so_out ^ so_oe_n};
        drv = drv | ~so_oe_n;
      end
    end
    sclk <= 1'b0;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge mclk);
    #1;
  endtask : frame
endmodule : fcs_host_model

// *** test/fcs_top_tb.sv ***
`timescale 1ns/100ps
module fcs_top_tb;
  import fcs_pkg::*;
  logic mclk, rst_b, clk_en, cs_n, sclk, si, so_out, so_oe_n;
  logic write_in_progress, nv_protect_mode_sel, nv_otp_lockdown;
  logic nv_factory_lock, otp_mode_active, ecc_fail_pulse, drv;
  logic cmd_check_fail, parity_check_fail, erase_done, erase_failed;
  logic program_done, program_failed, erase_suspend, erase_resume;
  logic program_suspend, program_resume, double_rate_octal_on;
  logic single_rate_octal_on, preamble_pattern_sel, parity_check_en;
  logic cmd_parity_fail_flag, protect_mode_sel, otp_lockdown_bit;
  logic otp_area_write_allow, array_access_allow, erase_fail_flag;
  logic program_fail_flag, erase_suspended_flag, program_suspended_flag;
  logic otp_prog_req, otp_prog_scur;
  logic [7:0]         nv_cfg_byte, otp_prog_byte, rd;
  logic [1:0]         ecc_fail_die;
  logic [2:0]         ecc_fail_kind, dummy_cycle_sel;
  logic [4:0]         dummy_cycle_count;
  logic [15:0]        preamble_main, preamble_io_line3;
  logic [CHUNK_W-1:0] ecc_fail_chunk;
  int                 mismatches = 0;
  int                 checks = 0;

  fcs_top DUT (.*);
  fcs_host_model host (.*);

  // 25 MHz system clock
  always #20 mclk = ~mclk;

  task automatic check(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic do_reset;
    @(posedge mclk) rst_b <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : do_reset

  task automatic rd_reg(input logic [31:0] a);
    host.frame({OP_RD_CFG2, a, 8'h00}, 40, 8, rd, drv);
  endtask : rd_reg

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    host.frame({OP_WR_CFG2, a, d}, 48, 0, rd, drv);
  endtask : wr_reg

  // boot codes 3, 2 and 1
  task automatic t_boot;
    logic [7:0] nv[3] = '{8'hff, 8'hf6, 8'hf5};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) nv_cfg_byte <= nv[i];
      do_reset;
      check("mode", {~nv[i][1:0]}, {double_rate_octal_on,
            single_rate_octal_on});
      check("parity_en", !nv[i][3], parity_check_en);
    end
    check("dummy_count", 16'h14, dummy_cycle_count);
    check("pre_main", PRE_MAIN, preamble_main);
    $display("test boot done");
  endtask : t_boot

  task automatic t_dummy;
    for (int c = 0; c < 8; c++) begin
      wr_reg(A_DUMMY, 8'(c));
      check("dummy_count", 16'(20 - 2 * c), dummy_cycle_count);
      rd_reg(A_DUMMY);
      check("dummy_read", 16'(c), rd);
      check("dummy_drive", 1'b1, drv);
    end
    $display("test dummy done");
  endtask : t_dummy

  task automatic t_preamble;
    for (int p = 1; p >= 0; p--) begin
      wr_reg(A_PREAMBLE, 8'(p));
      check("pre_main", p ? PRE_ALT : PRE_MAIN, preamble_main);
      check("pre_line3", p ? PRE_ALT : PRE_L3, preamble_io_line3);
    end
    $display("test preamble done");
  endtask : t_preamble

  // 18 failures; first address sticks
  task automatic t_ecc;
    logic [CHUNK_W-1:0] c0 = 22'h2a5c3b;
    logic [25:0] ea = {c0, 4'h0};
    @(posedge mclk);
    ecc_fail_die   <= 2'h1;
    ecc_fail_chunk <= c0;
    ecc_fail_pulse <= 1'b1;
    @(posedge mclk) ecc_fail_chunk <= ~c0;
    repeat (17) @(posedge mclk);
    ecc_fail_pulse <= 1'b0;
    rd_reg(A_ECC_STAT | 32'h0400_0000);
    check("ecc_stat_die1", 8'h9f, rd);
    for (int i = 0; i < 4; i++) begin
      rd_reg(A_FA0 + 32'(i) * 32'h100 | 32'h0400_0000);
      check("ecc_fail_addr", 8'(ea >> 8 * i), rd);
    end
    rd_reg(A_ECC_STAT);
    check("ecc_stat_die0", 8'h00, rd);
    wr_reg(A_ECC_STAT | 32'h0400_0000, CLEAR_VALUE);
    rd_reg(A_ECC_STAT | 32'h0400_0000);
    check("ecc_stat_clear", 8'h00, rd);
    @(posedge mclk);
    ecc_fail_die   <= 2'h3;
    ecc_fail_kind  <= 3'h2;
    ecc_fail_pulse <= 1'b1;
    @(posedge mclk) ecc_fail_pulse <= 1'b0;
    rd_reg(A_ECC_STAT | 32'h0c00_0000);
    check("ecc_stat_die3", 8'ha1, rd);
    $display("test ecc done");
  endtask : t_ecc

  // refused clear during write, then a real one
  task automatic t_flag;
    @(posedge mclk) cmd_check_fail <= 1'b1;
    @(posedge mclk) cmd_check_fail <= 1'b0;
    write_in_progress <= 1'b1;
    rd_reg(A_PAR_FAIL);
    check("fail_read", 8'h10, rd);
    rd_reg(A_DUMMY);
    check("refused_drive", 1'b0, drv);
    wr_reg(A_PAR_FAIL, CLEAR_VALUE);
    check("fail_flag", 1'b1, cmd_parity_fail_flag);
    @(posedge mclk) write_in_progress <= 1'b0;
    wr_reg(A_PAR_FAIL, CLEAR_VALUE);
    check("fail_flag", 1'b0, cmd_parity_fail_flag);
    @(posedge mclk) parity_check_fail <= 1'b1;
    @(posedge mclk) parity_check_fail <= 1'b0;
    #1;
    check("fail_flag", 1'b1, cmd_parity_fail_flag);
    $display("test flag done");
  endtask : t_flag

  task automatic t_security;
    @(posedge mclk);
    {nv_factory_lock, nv_protect_mode_sel} <= 2'b11;
    {erase_done, erase_failed, program_done, program_failed} <= 4'hf;
    {erase_suspend, program_suspend} <= 2'b11;
    @(posedge mclk);
    {erase_done, erase_failed, program_done, program_failed} <= 4'h0;
    {erase_suspend, program_suspend} <= 2'b00;
    host.frame({OP_RD_SCUR, 40'h0}, 8, 8, rd, drv);
    check("security", 8'hed, rd);
    host.frame({OP_WR_SCUR, 40'h0}, 8, 0, rd, drv);
    check("lock_prog", 16'h1ef, {otp_prog_scur, otp_prog_byte});
    @(posedge mclk);
    {erase_done, program_done, erase_resume, program_resume} <= 4'hf;
    {nv_otp_lockdown, otp_mode_active} <= 2'b11;
    @(posedge mclk);
    {erase_done, program_done, erase_resume, program_resume} <= 4'h0;
    host.frame({OP_RD_SCUR, 40'h0}, 8, 8, rd, drv);
    check("security", 8'h83, rd);
    check("otp_write_ok", 1'b0, otp_area_write_allow);
    check("array_ok", 1'b0, array_access_allow);
    $display("test security done");
  endtask : t_security

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // clk_en is the only tied input
  initial begin
    {mclk, rst_b, clk_en, write_in_progress, otp_mode_active} = 5'b00100;
    {nv_protect_mode_sel, nv_otp_lockdown, nv_factory_lock} = '0;
    {ecc_fail_pulse, cmd_check_fail, parity_check_fail} = '0;
    {erase_done, erase_failed, program_done, program_failed} = '0;
    {erase_suspend, erase_resume, program_suspend, program_resume} = '0;
    {ecc_fail_die, ecc_fail_kind, ecc_fail_chunk} = {2'h0, 3'h1, 22'h0};
    nv_cfg_byte = 8'hf5;
    do_reset;
    t_boot;
    t_dummy;
    t_preamble;
    t_ecc;
    t_flag;
    t_security;
    print_verdict;
  end

  // cut a hang well past the 12919-cycle run
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    print_verdict;
  end
endmodule : fcs_top_tb
